/* logic/io_bridge_pkg.sv */
package io_bridge_pkg;
  localparam int SYS_DATA_W    = 36;
  localparam int PERIPH_DATA_W = 16;
  localparam int PERIPH_ADDR_W = 18;
  localparam int CTRL_NUM_W    = 4;
  // command/address field positions on the system data lines
  localparam int CMD_IO_BIT    = 0;
  localparam int CMD_READ_BIT  = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam int CMD_BYTE_BIT  = 6;
  localparam int CTRL_NUM_LSB  = 14;
  localparam int REG_ADDR_LSB  = 18;
  // internal register space: addresses at or above this base belong to the bridge
  localparam logic [17:0] INT_REG_BASE = 18'h3E000;
  localparam logic [17:0] STATUS_ADDR  = 18'h3E010;
  localparam logic [17:0] MAINT_ADDR   = 18'h3E011;
  localparam int MAP_ADDR_W = 6;
  localparam int STAGE_LOC  = 2;
  // peripheral control line encodings
  localparam logic [1:0] CYC_DATI  = 2'h0;
  localparam logic [1:0] CYC_DATO  = 2'h2;
  localparam logic [1:0] CYC_DATOB = 2'h3;
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int MSYNC_DELAY_PS = 175000;
  localparam int MSYNC_DELAY_CYC = (MSYNC_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [SYS_DATA_W-1:0] STATUS_RST = 36'h000000000;
  localparam logic [SYS_DATA_W-1:0] MAINT_RST  = 36'h000000000;
endpackage

/* logic/periph_ctl_if.sv */
`timescale 1ns/1ps
interface periph_ctl_if;
  logic                                       start;
  logic                                       write;
  logic                                       byte_op;
  logic [io_bridge_pkg::PERIPH_ADDR_W-1:0]    addr;
  logic [io_bridge_pkg::PERIPH_DATA_W-1:0]    wdata;
  logic                                       end_pulse;
  logic [io_bridge_pkg::PERIPH_DATA_W-1:0]    rdata;
  logic                                       busy;
  logic [io_bridge_pkg::PERIPH_DATA_W-1:0]    pdata;
  modport ctl (output start, output write, output byte_op, output addr, output wdata,
               output pdata, input end_pulse, input rdata, input busy);
  modport eng (input start, input write, input byte_op, input addr, input wdata,
               input pdata, output end_pulse, output rdata, output busy);
endinterface

/* logic/periph_cycle_engine.sv */
`timescale 1ns/1ps
module periph_cycle_engine (
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  periph_ctl_if.eng  ctl,
  input  wire logic  arb_enable_i,
  input  wire logic  npr_req_s_i,
  input  wire logic  bbsy_s_i,
  input  wire logic  ssync_s_i,
  output logic       bbsy_o,
  output logic       msync_o,
  output logic [1:0] c_o,
  output logic       addr_oe_o,
  output logic       data_oe_o
);
  typedef enum logic [2:0] {E_IDLE, E_WAIT, E_SETUP, E_MSYNC, E_END} eng_state_e;
  eng_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [io_bridge_pkg::PERIPH_DATA_W-1:0] rd_q, rd_d;
  logic bbsy_d, msync_d, aoe_d, doe_d, end_q, end_d;
  logic [1:0] c_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    rd_d    = rd_q;
    bbsy_d  = bbsy_o;
    msync_d = msync_o;
    aoe_d   = addr_oe_o;
    doe_d   = data_oe_o;
    c_d     = c_o;
    end_d   = 1'b0;
    unique case (state_q)
      E_IDLE: if (ctl.start) state_d = E_WAIT;
      E_WAIT: begin
        if (arb_enable_i && !npr_req_s_i && !bbsy_s_i && !ssync_s_i) begin // R9
          state_d = E_SETUP;
          bbsy_d  = 1'b1; // R10
          aoe_d   = 1'b1;
          doe_d   = ctl.write;
          c_d     = !ctl.write ? io_bridge_pkg::CYC_DATI :
                    (ctl.byte_op ? io_bridge_pkg::CYC_DATOB : io_bridge_pkg::CYC_DATO); // R11
          cnt_d   = 8'(io_bridge_pkg::MSYNC_DELAY_CYC);
        end
      end
      E_SETUP: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          state_d = E_MSYNC;
          msync_d = 1'b1; // R12
        end
      end
      E_MSYNC: if (ssync_s_i) begin
        rd_d    = ctl.pdata; // R14
        state_d = E_END;
        msync_d = 1'b0; // R14
        end_d   = 1'b1;
      end
      E_END: begin
        state_d = E_IDLE; // R16
        bbsy_d  = 1'b0;
        aoe_d   = 1'b0;
        doe_d   = 1'b0;
        c_d     = io_bridge_pkg::CYC_DATI;
      end
      default: state_d = E_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q   <= E_IDLE;
      cnt_q     <= 8'h00;
      rd_q      <= 16'h0000;
      bbsy_o    <= 1'b0;
      msync_o   <= 1'b0;
      addr_oe_o <= 1'b0;
      data_oe_o <= 1'b0;
      c_o       <= 2'h0;
      end_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      rd_q      <= rd_d;
      bbsy_o    <= bbsy_d;
      msync_o   <= msync_d;
      addr_oe_o <= aoe_d;
      data_oe_o <= doe_d;
      c_o       <= c_d;
      end_q     <= end_d;
    end
  end

  assign ctl.end_pulse = end_q;
  assign ctl.rdata     = rd_q;
  assign ctl.busy      = (state_q != E_IDLE);
endmodule

/* logic/io_register_bus_bridge.sv */
`timescale 1ns/1ps
// Overview of operation
// (R1) master opens with command/address: io bit, read/write, byte, controller, address
// (R2) bridge raises io busy when addressed and holds it until access completes
// (R3) master follows a write command with its data cycle, no new request
// (R4) reads are answered later by the bridge requesting the system bus
// (R5) internal write data loads status/maintenance register or paging map entry
// (R6) io busy drops once the internal write is strobed
// (R7) internal read: request bus, select path, return data next clock, drop busy
// (R8) external write data is staged in location 2
// (R9) peripheral mastership needs arbiter enabled, no npr, no bbsy or ssync
// (R10) on mastership drive bbsy and address; write adds c1 and data; byte c0
// (R11) c lines encode dati 00, dato 10, datob 11
// (R12) msync rises 175 ns after address, bbsy, data and controls
// (R13) device latches or drives data on msync, then raises ssync
// (R14) on ssync capture data into location 2, drop msync, end cycle
// (R15) device drops ssync and read data after msync falls
// (R16) next clock: done, arbiter re-enabled, bbsy, address, data released
// (R17) writes drop io busy on completion; reads keep it until data returned
// (R18) after dati request bus, return staged data next clock, clear busy
module io_register_bus_bridge #(
  parameter logic [io_bridge_pkg::CTRL_NUM_W-1:0] CTRL_NUM = 4'h1
) (
  input  wire logic                                    mclk_i,
  input  wire logic                                    rst_n_i,
  input  wire logic                                    command_address_phase_i,
  input  wire logic                                    data_cycle_i,
  input  wire logic [io_bridge_pkg::SYS_DATA_W-1:0]    sys_data_i,
  input  wire logic                                    bus_grant_i,
  output logic                                         bus_request_o,
  output logic                                         io_busy_o,
  output logic                                         io_data_cycle_o,
  output logic [io_bridge_pkg::SYS_DATA_W-1:0]         sys_data_o,
  output logic                                         sys_data_oe_o,
  output logic [io_bridge_pkg::SYS_DATA_W-1:0]         status_reg_o,
  output logic [io_bridge_pkg::SYS_DATA_W-1:0]         maint_reg_o,
  input  wire logic                                    arb_enable_i,
  input  wire logic                                    npr_req_i,
  input  wire logic                                    bbsy_i,
  input  wire logic                                    ssync_i,
  input  wire logic [io_bridge_pkg::PERIPH_DATA_W-1:0] pdata_i,
  output logic                                         bbsy_o,
  output logic                                         msync_o,
  output logic [1:0]                                   c_o,
  output logic [io_bridge_pkg::PERIPH_ADDR_W-1:0]      paddr_o,
  output logic                                         paddr_oe_o,
  output logic [io_bridge_pkg::PERIPH_DATA_W-1:0]      pdata_o,
  output logic                                         pdata_oe_o
);
  // the engine counts the msync delay in an 8-bit counter
  if (io_bridge_pkg::MSYNC_DELAY_CYC < 1 ||
      io_bridge_pkg::MSYNC_DELAY_CYC > 255) begin : g_bad_delay
    $error("msync delay does not fit the counter");
  end

  typedef enum logic [2:0] {S_IDLE, S_WR_DATA, S_RD_INT, S_EXT, S_RD_EXT, S_RETURN} br_state_e;
  localparam int MAPN = 1 << io_bridge_pkg::MAP_ADDR_W;

  br_state_e state_q, state_d;
  logic [17:0] addr_q, addr_d;
  logic write_q, write_d, byte_q, byte_d;
  logic [io_bridge_pkg::PERIPH_DATA_W-1:0] stage_q [4];
  logic [io_bridge_pkg::SYS_DATA_W-1:0] map_q [MAPN];
  logic [io_bridge_pkg::SYS_DATA_W-1:0] ret_q, ret_d, status_d, maint_d;
  logic req_d, busy_d, dcyc_d, doe_d, start_q, start_d;
  logic stage_we, paging_map_write_pulse, internal_register_write_strobe;
  logic [io_bridge_pkg::PERIPH_DATA_W-1:0] stage_wd;
  logic [1:0] npr_sync_q, bbsy_sync_q, ssync_sync_q;
  logic [io_bridge_pkg::PERIPH_DATA_W-1:0] pd1_q, pd2_q;
  logic peripheral_cycle_end, peripheral_cycle_done_q;
  logic is_int, is_me, is_status;

  periph_ctl_if pif ();
  assign pif.start   = start_q;
  assign pif.write   = write_q;
  assign pif.byte_op = byte_q;
  assign pif.addr    = addr_q;
  assign pif.wdata   = stage_q[io_bridge_pkg::STAGE_LOC];
  assign pif.pdata   = pd2_q;
  assign peripheral_cycle_end = pif.end_pulse;

  periph_cycle_engine u_engine (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .ctl          (pif.eng),
    .arb_enable_i (arb_enable_i),
    .npr_req_s_i  (npr_sync_q[1]),
    .bbsy_s_i     (bbsy_sync_q[1]),
    .ssync_s_i    (ssync_sync_q[1]),
    .bbsy_o       (bbsy_o),
    .msync_o      (msync_o),
    .c_o          (c_o),
    .addr_oe_o    (paddr_oe_o),
    .data_oe_o    (pdata_oe_o)
  );

  always_comb begin
    is_me     = command_address_phase_i && sys_data_i[io_bridge_pkg::CMD_IO_BIT]
                && sys_data_i[io_bridge_pkg::CTRL_NUM_LSB +: io_bridge_pkg::CTRL_NUM_W]
                   == CTRL_NUM; // R1
    is_int    = addr_q >= io_bridge_pkg::INT_REG_BASE;
    is_status = addr_q == io_bridge_pkg::STATUS_ADDR;
    state_d   = state_q;
    addr_d    = addr_q;
    write_d   = write_q;
    byte_d    = byte_q;
    ret_d     = ret_q;
    status_d  = status_reg_o;
    maint_d   = maint_reg_o;
    req_d     = 1'b0;
    busy_d    = io_busy_o;
    dcyc_d    = 1'b0;
    doe_d     = 1'b0;
    start_d   = 1'b0;
    stage_we  = 1'b0;
    stage_wd  = pif.rdata;
    internal_register_write_strobe = 1'b0;
    paging_map_write_pulse         = 1'b0;
    unique case (state_q)
      S_IDLE: if (is_me) begin
        addr_d  = sys_data_i[io_bridge_pkg::REG_ADDR_LSB +: 18];
        write_d = sys_data_i[io_bridge_pkg::CMD_WRITE_BIT];
        byte_d  = sys_data_i[io_bridge_pkg::CMD_BYTE_BIT];
        busy_d  = 1'b1; // R2
        state_d = sys_data_i[io_bridge_pkg::CMD_WRITE_BIT] ? S_WR_DATA : S_RD_INT;
      end
      S_WR_DATA: if (data_cycle_i) begin // R3
        if (is_int) begin
          internal_register_write_strobe = 1'b1; // R5
          paging_map_write_pulse = !is_status && addr_q != io_bridge_pkg::MAINT_ADDR;
          if (is_status) status_d = sys_data_i;
          if (addr_q == io_bridge_pkg::MAINT_ADDR) maint_d = sys_data_i;
          busy_d  = 1'b0; // R6
          state_d = S_IDLE;
        end else begin
          stage_we = 1'b1; // R8
          stage_wd = sys_data_i[io_bridge_pkg::PERIPH_DATA_W-1:0];
          start_d  = 1'b1;
          state_d  = S_EXT;
        end
      end
      S_RD_INT: begin
        if (is_int) begin
          ret_d   = is_status ? status_reg_o :
                    (addr_q == io_bridge_pkg::MAINT_ADDR ? maint_reg_o
                     : map_q[addr_q[io_bridge_pkg::MAP_ADDR_W-1:0]]); // R7
          state_d = S_RETURN; // R4
        end else begin
          start_d = 1'b1;
          state_d = S_EXT;
        end
      end
      S_EXT: if (peripheral_cycle_end) begin
        stage_we = 1'b1; // R14
        state_d  = S_RD_EXT;
      end
      // wait until the engine has let go of the peripheral bus
      S_RD_EXT: if (peripheral_cycle_done_q && !pif.busy) begin // R16
        if (write_q) begin
          busy_d  = 1'b0; // R17
          state_d = S_IDLE;
        end else begin
          ret_d   = {{(io_bridge_pkg::SYS_DATA_W-io_bridge_pkg::PERIPH_DATA_W){1'b0}},
                     stage_q[io_bridge_pkg::STAGE_LOC]}; // R18
          state_d = S_RETURN;
        end
      end
      S_RETURN: begin
        req_d = !bus_grant_i; // R4
        if (bus_grant_i) begin
          dcyc_d  = 1'b1; // R7 R18
          doe_d   = 1'b1;
          busy_d  = 1'b0;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q       <= S_IDLE;
      addr_q        <= 18'h00000;
      write_q       <= 1'b0;
      byte_q        <= 1'b0;
      ret_q         <= 36'h000000000;
      status_reg_o  <= io_bridge_pkg::STATUS_RST;
      maint_reg_o   <= io_bridge_pkg::MAINT_RST;
      bus_request_o <= 1'b0;
      io_busy_o     <= 1'b0;
      io_data_cycle_o <= 1'b0;
      sys_data_oe_o <= 1'b0;
      sys_data_o    <= 36'h000000000;
      start_q       <= 1'b0;
      paddr_o       <= 18'h00000;
      pdata_o       <= 16'h0000;
      npr_sync_q    <= 2'h0;
      bbsy_sync_q   <= 2'h0;
      ssync_sync_q  <= 2'h0;
      pd1_q         <= 16'h0000;
      pd2_q         <= 16'h0000;
      peripheral_cycle_done_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      addr_q        <= addr_d;
      write_q       <= write_d;
      byte_q        <= byte_d;
      ret_q         <= ret_d;
      status_reg_o  <= status_d;
      maint_reg_o   <= maint_d;
      bus_request_o <= req_d;
      io_busy_o     <= busy_d;
      io_data_cycle_o <= dcyc_d;
      sys_data_oe_o <= doe_d;
      sys_data_o    <= dcyc_d ? ret_q : 36'h000000000;
      start_q       <= start_d;
      paddr_o       <= addr_q; // R10
      pdata_o       <= stage_q[io_bridge_pkg::STAGE_LOC];
      npr_sync_q    <= {npr_sync_q[0], npr_req_i};
      bbsy_sync_q   <= {bbsy_sync_q[0], bbsy_i};
      ssync_sync_q  <= {ssync_sync_q[0], ssync_i};
      pd1_q         <= pdata_i;
      pd2_q         <= pd1_q;
      peripheral_cycle_done_q <= peripheral_cycle_end; // R16
    end
  end

  always_ff @(posedge mclk_i) begin
    if (stage_we) stage_q[io_bridge_pkg::STAGE_LOC] <= stage_wd;
    if (paging_map_write_pulse) map_q[addr_q[io_bridge_pkg::MAP_ADDR_W-1:0]] <= sys_data_i;
  end
endmodule

/* sim/periph_dev_model.sv */
`timescale 1ns/1ps
module periph_dev_model (
  input  wire logic        mclk_i,
  input  wire logic        msync_i,
  input  wire logic [15:0] bus_i,
  input  wire logic [15:0] rval_i,
  input  wire logic [3:0]  dly_i,
  output logic             ssync_o,
  output logic [15:0]      drive_o,
  output logic [15:0]      got_o
);
  logic [3:0] cnt_q = 4'h0;
  initial begin
    ssync_o = 1'b0;
    drive_o = 16'h0;
    got_o = 16'h0;
  end
  always @(posedge mclk_i) begin
    if (msync_i && !ssync_o) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == dly_i) begin
        got_o <= bus_i;
        drive_o <= rval_i;
        ssync_o <= 1'b1;
      end
    end else if (!msync_i) begin
      cnt_q <= 4'h0;
      ssync_o <= 1'b0;
      drive_o <= ~rval_i;
    end
  end
endmodule

/* sim/io_bridge_props.sv */
`timescale 1ns/1ps
module io_bridge_props #(
  parameter logic [3:0] CTRL_NUM = 4'h1
) (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        command_address_phase_i,
  input wire logic        data_cycle_i,
  input wire logic [35:0] sys_data_i,
  input wire logic        bus_grant_i,
  input wire logic        bus_request_o,
  input wire logic        io_busy_o,
  input wire logic        io_data_cycle_o,
  input wire logic        sys_data_oe_o,
  input wire logic        arb_enable_i,
  input wire logic        npr_req_i,
  input wire logic        ssync_i,
  input wire logic        bbsy_o,
  input wire logic        msync_o,
  input wire logic [1:0]  c_o,
  input wire logic        paddr_oe_o,
  input wire logic        pdata_oe_o
);
  logic acc;
  logic int_wr_q;
  assign acc = command_address_phase_i && sys_data_i[0] && !io_busy_o
               && sys_data_i[17:14] == CTRL_NUM;
  // remembers whether the access in flight is an internal write
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) int_wr_q <= 1'b0;
    else if (acc) int_wr_q <= sys_data_i[2] && sys_data_i[35:18] >= io_bridge_pkg::INT_REG_BASE;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  busy_on_cmd_a: assert property (acc |=> io_busy_o)
    else $error("io busy not raised");
  int_wr_end_a: assert property (int_wr_q && io_busy_o && data_cycle_i |=> !io_busy_o)
    else $error("io busy kept after internal write");
  late_return_a: assert property (io_data_cycle_o |-> $past(bus_grant_i, 2) || $past(bus_grant_i))
    else $error("read data without grant");
  grant_ret_a: assert property (bus_request_o && bus_grant_i |-> ##[1:2]
    (io_data_cycle_o && sys_data_oe_o) ##1 (!io_data_cycle_o && !io_busy_o))
    else $error("read return cycle wrong");
  arb_gate_a: assert property ((!arb_enable_i)[*3] |=> !$rose(bbsy_o))
    else $error("mastership while arbiter off");
  npr_gate_a: assert property (npr_req_i[*4] |=> !$rose(bbsy_o))
    else $error("mastership during npr");
  msync_delay_a: assert property ($rose(bbsy_o) |-> (!msync_o)[*7] ##1 msync_o)
    else $error("msync delay wrong");
  bus_held_a: assert property (msync_o |-> bbsy_o && paddr_oe_o
    && pdata_oe_o == c_o[1] && c_o != 2'h1)
    else $error("peripheral lines wrong during msync");
  msync_end_a: assert property (msync_o && ssync_i |-> ##[1:4] !msync_o)
    else $error("msync not dropped");
  release_a: assert property ($fell(msync_o) |-> ##[1:3] (!bbsy_o && !paddr_oe_o && !pdata_oe_o))
    else $error("bus not released");
  wr_done_a: assert property ($fell(bbsy_o) && $past(c_o[1]) |-> ##[0:2] !io_busy_o)
    else $error("io busy kept after write");
  rd_hold_a: assert property ($fell(bbsy_o) && !$past(c_o[1]) |-> io_busy_o)
    else $error("io busy dropped before return");
endmodule
bind io_register_bus_bridge io_bridge_props #(.CTRL_NUM(CTRL_NUM)) u_io_bridge_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .command_address_phase_i(command_address_phase_i),
  .data_cycle_i(data_cycle_i), .sys_data_i(sys_data_i), .bus_grant_i(bus_grant_i),
  .bus_request_o(bus_request_o), .io_busy_o(io_busy_o), .io_data_cycle_o(io_data_cycle_o),
  .sys_data_oe_o(sys_data_oe_o), .arb_enable_i(arb_enable_i), .npr_req_i(npr_req_i),
  .ssync_i(ssync_i), .bbsy_o(bbsy_o), .msync_o(msync_o), .c_o(c_o),
  .paddr_oe_o(paddr_oe_o), .pdata_oe_o(pdata_oe_o)
);

/* sim/io_register_bus_bridge_bench.sv */
`timescale 1ns/1ps
module io_register_bus_bridge_bench;
  logic        clk = 1'b0, rst_n = 1'b0, cap = 1'b0, dcy = 1'b0, gnt = 1'b0;
  logic        arb = 1'b1, npr = 1'b0, obsy = 1'b0, hit = 1'b0;
  logic [35:0] sdi = 36'h0;
  logic [15:0] rval = 16'h0, pw, drv, got, pdo;
  logic [3:0]  dly = 4'h0;
  logic        req, busy, dcyc, sdoe, bbsy, msync, paoe, pdoe, ssync;
  logic [35:0] sdo, st, mt;
  logic [17:0] paddr, sa;
  logic [1:0]  c, sc;
  logic [2:0]  flags;
  int          fail_count = 0, n_tests = 0;
  assign pw = pdoe ? pdo : drv;
  assign flags = {dcyc, req, busy};
  io_register_bus_bridge u_io_register_bus_bridge (
    .mclk_i(clk), .rst_n_i(rst_n), .command_address_phase_i(cap), .data_cycle_i(dcy),
    .sys_data_i(sdi), .bus_grant_i(gnt), .bus_request_o(req), .io_busy_o(busy),
    .io_data_cycle_o(dcyc), .sys_data_o(sdo), .sys_data_oe_o(sdoe), .status_reg_o(st),
    .maint_reg_o(mt), .arb_enable_i(arb), .npr_req_i(npr), .bbsy_i(obsy), .ssync_i(ssync),
    .pdata_i(pw), .bbsy_o(bbsy), .msync_o(msync), .c_o(c), .paddr_o(paddr),
    .paddr_oe_o(paoe), .pdata_o(pdo), .pdata_oe_o(pdoe));
  periph_dev_model u_periph_dev_model (.mclk_i(clk), .msync_i(msync), .bus_i(pw),
    .rval_i(rval), .dly_i(dly), .ssync_o(ssync), .drive_o(drv), .got_o(got));
  initial forever #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (msync === 1'b1) begin
      sa = paddr;
      sc = c;
    end
    if (bbsy === 1'b1) hit = 1'b1;
  end
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_hi(input int idx, input logic v);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (flags[idx] !== v && k < 400);
    if (k == 400) chk(36'h1, 36'h0);
  endtask
  task automatic cmd(input logic wr, input logic byt, input logic [3:0] ctl,
                     input logic [17:0] a, input logic [35:0] d);
    wait_hi(0, 1'b0);
    @(posedge clk);
    cap <= 1'b1;
    sdi <= {a, ctl, 7'h0, byt, 3'h0, wr, !wr, 1'b1};
    @(posedge clk);
    cap <= 1'b0;
    if (wr) begin
      sdi <= d;
      dcy <= 1'b1;
      @(posedge clk);
      dcy <= 1'b0;
    end
  endtask
  task automatic fetch(output logic [35:0] v);
    wait_hi(1, 1'b1);
    @(posedge clk);
    gnt <= 1'b1;
    @(posedge clk);
    gnt <= 1'b0;
    wait_hi(2, 1'b1);
    v = sdo;
    chk(sdoe, 36'h1);
  endtask
  task automatic t_int();
    logic [35:0] v;
    cmd(1'b1, 1'b0, 4'h1, io_bridge_pkg::STATUS_ADDR, 36'h987654321);
    wait_hi(0, 1'b0);
    chk(st, 36'h987654321);
    cmd(1'b1, 1'b0, 4'h1, io_bridge_pkg::MAINT_ADDR, 36'h123456789);
    wait_hi(0, 1'b0);
    chk(mt, 36'h123456789);
    cmd(1'b1, 1'b0, 4'h1, 18'h3E005, 36'h7A5);
    cmd(1'b0, 1'b0, 4'h1, 18'h3E005, 36'h0);
    fetch(v);
    chk(v, 36'h7A5);
    cmd(1'b0, 1'b0, 4'h1, io_bridge_pkg::STATUS_ADDR, 36'h0);
    fetch(v);
    chk(v, 36'h987654321);
    cmd(1'b1, 1'b0, 4'h2, io_bridge_pkg::MAINT_ADDR, 36'h0);
    @(negedge clk);
    chk(busy, 1'b0);
    chk(mt, 36'h123456789);
    $display("internal access test done");
  endtask
  task automatic t_ext();
    logic [35:0] v;
    logic [35:0] wd;
    for (int i = 0; i < 3; i++) begin
      wd = 36'h7E81 + 36'(i);
      @(posedge clk);
      dly <= 4'(i * 4);
      rval <= 16'hC3A0;
      cmd(i > 0, i == 2, 4'h1, 18'h00F00 + 18'(i), wd);
      if (i == 0) begin
        fetch(v);
        chk(v[15:0], 16'hC3A0);
      end else begin
        wait_hi(0, 1'b0);
        chk(got, wd[15:0]);
      end
      chk(sa, 18'h00F00 + 18'(i));
      chk(sc, {i > 0, i == 2});
    end
    $display("external access test done");
  endtask
  task automatic t_arb();
    @(posedge clk);
    arb <= 1'b0;
    hit = 1'b0;
    cmd(1'b1, 1'b0, 4'h1, 18'h00F10, 36'h1B2C);
    repeat (20) @(posedge clk);
    npr <= 1'b1;
    // npr must be through its synchroniser before the arbiter opens
    repeat (4) @(posedge clk);
    arb <= 1'b1;
    repeat (20) @(posedge clk);
    npr <= 1'b0;
    obsy <= 1'b1;
    repeat (20) @(posedge clk);
    chk(hit, 1'b0);
    obsy <= 1'b0;
    wait_hi(0, 1'b0);
    chk(got, 16'h1B2C);
    $display("arbitration test done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_int();
    t_ext();
    t_arb();
    end_sim();
  end
  initial begin
    repeat (8000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule
